// file: hdl/spsq_pkg.sv
// Purpose: Shared constants for the stepper phase sequencer.
// Assumes: mclk runs at 50 MHz.
// Notes: Phase index 0 is the power-on state with first winding and second negative winding on.
package spsq_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_MIN_PULSE_NS = 10000;
  localparam int STEP_MIN_PULSE_CYC = (STEP_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Glitch filter: level must stand this many samples, far below a legal pulse
  localparam int FILT_LEN = 3;
  // Filtered input indices
  localparam int NUM_IN = 5;
  localparam int IN_STEP = 0;
  localparam int IN_DIR = 1;
  localparam int IN_MODE = 2;
  localparam int IN_EN = 3;
  localparam int IN_RSTN = 4;
  // Sequencer
  localparam int POS_W = 3;
  localparam logic [POS_W-1:0] POS_INIT = 3'h0;
  localparam int WIND_W = 4;
  // Winding vector order: {first, firstNeg, second, secondNeg}
  localparam logic [WIND_W-1:0] WIND_OFF = 4'h0;
  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam int CTRL_HOLD_OFF_BIT = 0;
  localparam logic CTRL_HOLD_OFF_RST = 1'b0;
  localparam int ST_POS_LSB = 0;
  localparam int ST_MODE_BIT = 3;
  localparam int ST_DIR_BIT = 4;
  localparam int ST_EN_BIT = 5;
  localparam int ST_RST_BIT = 6;
  localparam int ST_DRIVE_BIT = 7;
endpackage

// file: hdl/spsq_sequencer.sv
// Purpose: Four-winding phase sequencer for a unipolar two-phase stepping motor.
// Assumes: All pins synchronous-ish to mclk; step pulses last far longer than FILT_LEN cycles.
// Notes: Summary of operation below; bus holds a hold-off control and a status word.
//
// Summary of operation
// R1: Controller holds system_reset_low low at least 10 us after power-up.
// R2: After reset the sequence starts with the first winding gate switched on first.
// R3: The step clock advances the sequence only on its rising edge.
// R4: Controller keeps step clock at most 50 kHz, each level at least 10 us.
// R5: direction_select level chooses which way the sequence steps.
// R6: Controller keeps direction_select stable 6.25 us around each step edge.
// R7: Enable low forces all four windings off; enable high drives them normally.
// R8: After enable returns high, excitation resumes from the continued phase.
// R9: Controller drives enable high from the start of operation.
// R10: Mode low selects two-phase full step; mode high selects one-two-phase half step.
// R11: Controller keeps mode stable 5 us around each step edge.
// R12: In two-phase mode each winding stays on for two step periods.
// R13: In one-two-phase mode each winding stays on for three step periods.
// R14: Without step edges the present excitation is held, windings stay driven.
// R15: direction_select low steps forward, high steps reverse.
// R16: system_reset_low low resets the sequencer and turns all windings off.
// R17: A mode change keeps position; the sequence continues from the present phase.
// R18: A mode change close to a step edge may apply one step late.
// R19: Four states in full step, eight in half step, reversed order for reverse.
// R20: All pin inputs are synchronised and glitch filtered before use.
// R21: Enable changes only gate the windings, never the phase or direction.
`timescale 1ns/1ps
module spsq_sequencer (
  input wire logic mclk, // 50 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic stepClk, // Step clock pin
  input wire logic directionSelect, // Direction pin, low forward
  input wire logic modeSelect, // Mode pin, low full step
  input wire logic enableIn, // Winding enable pin, high drives
  input wire logic systemResetLow, // Sequencer reset pin, active low
  input wire logic [spsq_pkg::ADDR_W-1:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [spsq_pkg::DATA_W-1:0] avs_writedata, // Avalon write data
  output logic [spsq_pkg::DATA_W-1:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  output logic firstWinding, // First winding gate
  output logic firstWindingNeg, // First negative winding gate
  output logic secondWinding, // Second winding gate
  output logic secondWindingNeg // Second negative winding gate
);
  import spsq_pkg::*;

  logic [NUM_IN-1:0] syncA_reg;
  logic [NUM_IN-1:0] syncB_reg;
  logic [FILT_LEN-1:0] hist_reg [NUM_IN];
  logic [NUM_IN-1:0] filt_reg;
  logic stepPrev_reg;
  logic stepEdge;
  logic resetActive;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  logic [WIND_W-1:0] wind_reg;
  logic [WIND_W-1:0] wind_next;
  logic holdOff_reg;
  logic waitReq_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic busReq;

  // Winding pattern for each phase index
  function automatic logic [WIND_W-1:0] spsqPattern(input logic [POS_W-1:0] p);
    logic [WIND_W-1:0] w;
    w = WIND_OFF;
    case (p)
      3'h0: w = 4'h9;
      3'h1: w = 4'h8;
      3'h2: w = 4'hA;
      3'h3: w = 4'h2;
      3'h4: w = 4'h6;
      3'h5: w = 4'h4;
      3'h6: w = 4'h5;
      3'h7: w = 4'h1;
      default: w = WIND_OFF;
    endcase
    return w;
  endfunction

  // Next phase index: half step moves one, full step lands on the next even index
  function automatic logic [POS_W-1:0] spsqNextPos(input logic [POS_W-1:0] p, input logic rev, input logic half);
    logic [POS_W-1:0] d;
    d = (half || p[0]) ? 3'h1 : 3'h2;
    return rev ? POS_W'(p - d) : POS_W'(p + d);
  endfunction

  // Two-flop synchronisers for all pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
    end else begin
      syncA_reg <= {systemResetLow, enableIn, modeSelect, directionSelect, stepClk};
      syncB_reg <= syncA_reg;
    end
  end

  // Glitch filter: a level change needs FILT_LEN equal samples
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_IN; i++) begin
        hist_reg[i] <= '0;
      end
      filt_reg <= 5'h00;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        hist_reg[i] <= {hist_reg[i][FILT_LEN-2:0], syncB_reg[i]}; // [R20]
        if (&hist_reg[i]) begin
          filt_reg[i] <= 1'b1;
        end else if (~|hist_reg[i]) begin
          filt_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Rising edge of the filtered step clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stepPrev_reg <= 1'b0;
    end else begin
      stepPrev_reg <= filt_reg[IN_STEP];
    end
  end

  assign stepEdge = filt_reg[IN_STEP] && !stepPrev_reg; // [R3]
  assign resetActive = !filt_reg[IN_RSTN];

  // Phase index update; enable plays no part here
  always_comb begin
    pos_next = pos_reg; // [R14] [R21]
    if (resetActive) begin
      pos_next = POS_INIT; // [R2] [R16]
    end else if (stepEdge) begin
      // Mode and direction taken at the edge, position kept across mode changes
      pos_next = spsqNextPos(pos_reg, filt_reg[IN_DIR], filt_reg[IN_MODE]); // [R5] [R10] [R15] [R17] [R18] [R19]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pos_reg <= POS_INIT; // [R2]
    end else begin
      pos_reg <= pos_next; // [R8]
    end
  end

  // Winding outputs, gated by reset, enable and software hold-off
  always_comb begin
    wind_next = spsqPattern(pos_reg); // [R12] [R13]
    if (resetActive || !filt_reg[IN_EN] || holdOff_reg) begin
      wind_next = WIND_OFF; // [R7] [R16]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wind_reg <= WIND_OFF;
    end else begin
      wind_reg <= wind_next;
    end
  end

  assign firstWinding = wind_reg[3];
  assign firstWindingNeg = wind_reg[2];
  assign secondWinding = wind_reg[1];
  assign secondWindingNeg = wind_reg[0];

  // Avalon slave: one wait cycle, then the answer
  assign busReq = avs_read || avs_write;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      waitReq_reg <= 1'b1;
    end else begin
      waitReq_reg <= !(busReq && waitReq_reg);
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    case (avs_address)
      CTRL_OFS: rdata_next[CTRL_HOLD_OFF_BIT] = holdOff_reg;
      STATUS_OFS: begin
        rdata_next[ST_POS_LSB +: POS_W] = pos_reg;
        rdata_next[ST_MODE_BIT] = filt_reg[IN_MODE];
        rdata_next[ST_DIR_BIT] = filt_reg[IN_DIR];
        rdata_next[ST_EN_BIT] = filt_reg[IN_EN];
        rdata_next[ST_RST_BIT] = resetActive;
        rdata_next[ST_DRIVE_BIT] = |wind_reg;
      end
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else if (avs_read && waitReq_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = waitReq_reg;

  // Control register write, taken at the edge where waitrequest is low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      holdOff_reg <= CTRL_HOLD_OFF_RST;
    end else if (avs_write && !waitReq_reg && avs_address == CTRL_OFS) begin
      holdOff_reg <= avs_writedata[CTRL_HOLD_OFF_BIT];
    end
  end

  // Checks on the sequencer
  reset_init_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
    resetActive |=> pos_reg == POS_INIT && wind_reg == WIND_OFF)
    else $error("phase not at initial state after reset");

  reset_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R16]
    resetActive |=> wind_reg == WIND_OFF)
    else $error("windings driven during reset");

  enable_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
    !filt_reg[IN_EN] |=> wind_reg == WIND_OFF)
    else $error("windings driven while enable low");

  drive_match_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
    (filt_reg[IN_EN] && !resetActive && !holdOff_reg) |=> wind_reg == spsqPattern($past(pos_reg)))
    else $error("windings do not follow phase");

  hold_still_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R14]
    (!stepEdge && !resetActive) |=> $stable(pos_reg))
    else $error("phase moved without step edge");

  half_fwd_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
    (stepEdge && !resetActive && filt_reg[IN_MODE] && !filt_reg[IN_DIR])
      |=> pos_reg == POS_W'($past(pos_reg) + 3'h1))
    else $error("half step forward wrong");

  half_rev_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R19]
    (stepEdge && !resetActive && filt_reg[IN_MODE] && filt_reg[IN_DIR])
      |=> pos_reg == POS_W'($past(pos_reg) - 3'h1))
    else $error("half step reverse wrong");

  full_even_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
    (stepEdge && !resetActive && !filt_reg[IN_MODE]) |=> !pos_reg[0] && pos_reg != $past(pos_reg))
    else $error("full step not on two-phase state");

  enable_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R21]
    ($changed(filt_reg[IN_EN]) && !stepEdge && !resetActive) |=> $stable(pos_reg))
    else $error("enable change moved phase");

  step_filter_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R20]
    stepEdge |-> $past(hist_reg[IN_STEP]) == {FILT_LEN{1'b1}})
    else $error("step edge without filtered level");

  bus_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (busReq && waitReq_reg) |=> !waitReq_reg ##1 waitReq_reg)
    else $error("bus answer not one wait cycle");

  // Further checks on full stepping, reset exit, enable return and the bus
  full_fwd_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
    (stepEdge && !resetActive && !filt_reg[IN_MODE] && !filt_reg[IN_DIR] && !pos_reg[0])
      |=> pos_reg == POS_W'($past(pos_reg) + 3'h2))
    else $error("full step forward wrong");

  full_rev_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R19]
    (stepEdge && !resetActive && !filt_reg[IN_MODE] && filt_reg[IN_DIR] && !pos_reg[0])
      |=> pos_reg == POS_W'($past(pos_reg) - 3'h2))
    else $error("full step reverse wrong");

  mode_odd_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R17]
    (stepEdge && !resetActive && !filt_reg[IN_MODE] && pos_reg[0])
      |=> pos_reg == ($past(filt_reg[IN_DIR]) ? POS_W'($past(pos_reg) - 3'h1) : POS_W'($past(pos_reg) + 3'h1)))
    else $error("mode change lost position");

  reset_exit_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
    ($fell(resetActive) && filt_reg[IN_EN] && !holdOff_reg)
      |-> pos_reg == POS_INIT ##1 wind_reg == spsqPattern(POS_INIT))
    else $error("first excitation after reset wrong");

  enable_resume_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
    ($rose(filt_reg[IN_EN]) && !resetActive && !holdOff_reg) |=> wind_reg == spsqPattern($past(pos_reg)))
    else $error("windings did not resume at continued phase");

  hold_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    holdOff_reg |=> wind_reg == WIND_OFF)
    else $error("windings driven during hold-off");

  bus_refuse_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (avs_write && avs_address != CTRL_OFS) |=> $stable(holdOff_reg))
    else $error("write to a read-only address took effect");

  read_word_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (avs_read && waitReq_reg && avs_address == STATUS_OFS) |=> avs_readdata[ST_POS_LSB +: POS_W] == $past(pos_reg))
    else $error("status read lost phase index");

endmodule

// file: testbench/spsq_host_model.sv
// Purpose: Host controller model driving the sequencer pins.
// Assumes: mclk at 50 MHz; every task is entered just after a rising edge.
// Notes: glitch makes a step pulse far below the legal width on purpose.
`timescale 1ns/1ps
module spsq_host_model (
  input wire logic mclk, // Bench clock
  output logic stepClk, // Step clock pin
  output logic directionSelect, // Direction pin
  output logic modeSelect, // Mode pin
  output logic enableIn, // Enable pin
  output logic systemResetLow // Sequencer reset pin
);
  localparam int HALF = 500; // 10 us per step level at 20 ns
  // Power-up levels: reset asserted, enable high from the start
  initial begin
    stepClk = 1'b0;
    directionSelect = 1'b0;
    modeSelect = 1'b0;
    enableIn = 1'b1;
    systemResetLow = 1'b0;
  end
  // Wait a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Reset pin level, enable kept high, then n edges
  task automatic rst_pin(input logic v, input int n);
    systemResetLow <= v;
    enableIn <= 1'b1;
    tick(n);
  endtask
  // Levels set a full low time before the rising step edge
  task automatic step_rise(input logic d, input logic m, input logic e);
    directionSelect <= d;
    modeSelect <= m;
    enableIn <= e;
    tick(HALF);
    stepClk <= 1'b1;
    tick(HALF);
  endtask
  // Falling step edge, then a full low time
  task automatic step_fall();
    stepClk <= 1'b0;
    tick(HALF);
  endtask
  // Step pulse of two samples only
  task automatic glitch();
    stepClk <= 1'b1;
    tick(2);
    stepClk <= 1'b0;
    tick(HALF);
  endtask
endmodule

// file: testbench/tb.sv
// Purpose: Self-checking bench for the stepper phase sequencer.
// Assumes: mclk 50 MHz; host model drives the pins, the bench drives the bus.
// Notes: Expected windings and read words are queued and compared by monitors.
`timescale 1ns/1ps
module tb;
  import spsq_pkg::*;
  localparam logic [3:0] PAT [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
  logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic stepClk, directionSelect, modeSelect, enableIn, systemResetLow;
  logic firstWinding, firstWindingNeg, secondWinding, secondWindingNeg;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0] windQ [$];
  logic [DATA_W-1:0] readQ [$];
  logic [POS_W-1:0] pos;
  logic [3:0] r;
  logic dir, mode, en, hold, rstAct;
  int fails, n_checks;
  event chk;
  spsq_sequencer spsq_sequencer_i (.mclk(mclk), .sys_rst(sys_rst), .stepClk(stepClk),
    .directionSelect(directionSelect), .modeSelect(modeSelect), .enableIn(enableIn),
    .systemResetLow(systemResetLow), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .firstWinding(firstWinding), .firstWindingNeg(firstWindingNeg),
    .secondWinding(secondWinding), .secondWindingNeg(secondWindingNeg));
  spsq_host_model spsq_host_model_i (.mclk(mclk), .stepClk(stepClk), .directionSelect(directionSelect),
    .modeSelect(modeSelect), .enableIn(enableIn), .systemResetLow(systemResetLow));
  // Clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Compare tasks, one per kind of result
  task automatic cmp_wind(input logic [3:0] e, input logic [3:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch windings expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_word(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch readdata expected %h seen %h", e, s);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Expected status word from the bench's own state
  function automatic logic [DATA_W-1:0] status_exp();
    logic [3:0] w;
    w = (en && !hold && !rstAct) ? PAT[pos] : 4'h0;
    return {24'h0, |w, rstAct, en, dir, mode, pos};
  endfunction
  // Note the expected windings and wake the monitor
  task automatic note();
    windQ.push_back((en && !hold && !rstAct) ? PAT[pos] : 4'h0);
    ->chk;
  endtask
  // Avalon cycle: hold until waitrequest is sampled low, then release
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    if (!w) readQ.push_back(d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
    @(posedge mclk);
  endtask
  // One step with its expected next phase, checked after each edge
  task automatic do_step(input logic d, input logic m, input logic e);
    dir = d;
    mode = m;
    en = e;
    spsq_host_model_i.step_rise(d, m, e);
    pos = (m || pos[0]) ? (d ? pos - 3'h1 : pos + 3'h1) : (d ? pos - 3'h2 : pos + 3'h2);
    note();
    spsq_host_model_i.step_fall();
    note();
  endtask
  // Winding monitor: oldest note against present outputs
  initial forever begin
    @(chk);
    cmp_wind(windQ.pop_front(), {firstWinding, firstWindingNeg, secondWinding, secondWindingNeg});
  end
  // Read monitor: oldest note against data on the accepting edge
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      cmp_word(readQ.pop_front(), avs_readdata);
    end
  end
  // Hang guard
  initial begin
    repeat (95000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    pos = POS_INIT;
    {dir, mode, en, hold, rstAct} = 5'h04;
    fails = 0;
    n_checks = 0;
    void'($urandom(36068));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    spsq_host_model_i.rst_pin(1'b0, 510);
    spsq_host_model_i.rst_pin(1'b1, 20);
    note();
    bus(1'b0, CTRL_OFS, {31'h0, CTRL_HOLD_OFF_RST});
    bus(1'b0, STATUS_OFS, status_exp());
    // Random walk over direction, mode and enable
    repeat (40) begin
      r = 4'($urandom);
      do_step(r[0], r[1], r[2] | r[3]);
      bus(1'b0, STATUS_OFS, status_exp());
    end
    // Hold without steps, then a short glitch
    do_step(1'b0, 1'b1, 1'b1);
    spsq_host_model_i.tick(2000);
    note();
    spsq_host_model_i.glitch();
    note();
    // Hold-off control, bus refusals, phase still counted
    bus(1'b1, CTRL_OFS, 32'h1);
    hold = 1'b1;
    bus(1'b0, CTRL_OFS, 32'h1);
    note();
    do_step(1'b1, 1'b0, 1'b1);
    bus(1'b0, 4'h8, 32'h0);
    bus(1'b1, STATUS_OFS, 32'hFF);
    bus(1'b0, STATUS_OFS, status_exp());
    bus(1'b1, CTRL_OFS, 32'h0);
    hold = 1'b0;
    spsq_host_model_i.tick(4);
    note();
    // Mid-run sequencer reset, then a full step from the start
    spsq_host_model_i.rst_pin(1'b0, 510);
    {pos, en, rstAct} = {POS_INIT, 2'h3};
    note();
    bus(1'b0, STATUS_OFS, status_exp());
    spsq_host_model_i.rst_pin(1'b1, 20);
    rstAct = 1'b0;
    note();
    do_step(1'b0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
